// ==== core/aowte_engine.sv ====
// Module: output waveform timing engine with register port
`timescale 1ns/1ps
module aowte_engine
	import aowte_pkg::*;
#(
	parameter int PFI_N = 10,
	parameter int DATA_W = 32
) (
	input wire logic clk_sys_i,
	input wire logic resetn_i,
	input wire logic [7:0] reg_addr_i,
	input wire logic [31:0] reg_wdata_i,
	input wire logic reg_wr_i,
	input wire logic reg_rd_i,
	output logic [31:0] reg_rdata_o,
	input wire logic [PFI_N-1:0] pfi_i,
	input wire logic [SYNC_N-1:0] sync_line_i,
	input wire logic fast_internal_timebase_i,
	input wire logic slow_internal_timebase_i,
	input wire logic analog_threshold_event_i,
	input wire logic run_trigger_pin_i,
	output logic run_trigger_pin_o,
	output logic run_trigger_pin_oe_o,
	input wire logic update_strobe_pin_i,
	output logic update_strobe_pin_o,
	output logic update_strobe_pin_oe_o,
	output logic board_root_timebase_o,
	input wire logic fifo_valid_i,
	input wire logic [DATA_W-1:0] fifo_data_i,
	output logic fifo_pop_o,
	output logic [DATA_W-1:0] dac_data_o,
	output logic dac_update_o,
	output logic underflow_o
);
	localparam int SRC_N = PFI_N + SYNC_N + 3;

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	function automatic logic pick(input logic [SRC_N-1:0] v,
		input logic [SEL_W-1:0] idx);
		pick = (int'(idx) < SRC_N) ? v[idx] : 1'b0;
	endfunction : pick

	function automatic logic edge_of(input logic cur, input logic prev,
		input logic fall);
		edge_of = fall ? (prev & ~cur) : (cur & ~prev);
	endfunction : edge_of

	// ----------------------------------------
	// Reset release
	// ----------------------------------------
	logic [1:0] rst_sync_reg;
	logic rst_n;
	always_ff @(posedge clk_sys_i or negedge resetn_i) begin
		if (!resetn_i) begin
			rst_sync_reg <= 2'h0;
		end else begin
			rst_sync_reg <= {rst_sync_reg[0], 1'b1};
		end
	end
	assign rst_n = rst_sync_reg[1];

	// ----------------------------------------
	// Registers
	// ----------------------------------------
	aowte_ctrl_t ctrl_reg;
	aowte_route_t route_reg;
	logic [CNT_W-1:0] divisor_reg;
	logic [CNT_W-1:0] delay_reg;
	logic [CNT_W-1:0] count_reg;
	logic [CNT_W-1:0] produced_reg;
	logic underflow_reg;
	logic [31:0] rdata_reg;
	aowte_state_t state_reg;
	logic wr_ctrl;
	logic start_cmd;
	logic stop_cmd;
	logic uf_clear;

	assign wr_ctrl = reg_wr_i && (reg_addr_i == ADDR_CTRL);
	assign start_cmd = wr_ctrl && reg_wdata_i[CTRL_START_BIT];
	assign stop_cmd = wr_ctrl && reg_wdata_i[CTRL_STOP_BIT];
	assign uf_clear = reg_wr_i && (reg_addr_i == ADDR_STATUS) &&
		reg_wdata_i[STAT_UNDERFLOW_BIT];

	always_ff @(posedge clk_sys_i or negedge rst_n) begin
		if (!rst_n) begin
			ctrl_reg <= CTRL_RESET;
			route_reg <= ROUTE_RESET;
			divisor_reg <= DIVISOR_RESET;
			delay_reg <= DELAY_RESET;
			count_reg <= COUNT_RESET;
		end else if (reg_wr_i) begin
			case (reg_addr_i)
				ADDR_CTRL: begin
					ctrl_reg <= aowte_ctrl_t'(reg_wdata_i[15:0]);
				end
				ADDR_ROUTE: begin
					route_reg <= aowte_route_t'(reg_wdata_i[19:0]);
				end
				ADDR_DIVISOR: begin
					divisor_reg <= reg_wdata_i[CNT_W-1:0];
				end
				ADDR_DELAY: begin
					delay_reg <= reg_wdata_i[CNT_W-1:0];
				end
				ADDR_COUNT: begin
					count_reg <= reg_wdata_i[CNT_W-1:0];
				end
				default: begin
				end
			endcase
		end
	end

	// Unmapped addresses read as zero
	always_ff @(posedge clk_sys_i or negedge rst_n) begin
		if (!rst_n) begin
			rdata_reg <= 32'h0;
		end else if (reg_rd_i) begin
			case (reg_addr_i)
				ADDR_CTRL: rdata_reg <= {16'h0, ctrl_reg};
				ADDR_ROUTE: rdata_reg <= {12'h0, route_reg};
				ADDR_DIVISOR: rdata_reg <= {8'h0, divisor_reg};
				ADDR_DELAY: rdata_reg <= {8'h0, delay_reg};
				ADDR_COUNT: rdata_reg <= {8'h0, count_reg};
				ADDR_STATUS: rdata_reg <= {27'h0, underflow_reg, state_reg};
				ADDR_PRODUCED: rdata_reg <= {8'h0, produced_reg};
				default: rdata_reg <= 32'h0;
			endcase
		end else begin
			rdata_reg <= 32'h0;
		end
	end
	assign reg_rdata_o = rdata_reg;

	// ----------------------------------------
	// Source routing
	// ----------------------------------------
	// Pin inputs are taken as synchronous; one delay stage gives edges.
	// External sources must stay below half the sampling rate to be seen.
	logic [SRC_N-1:0] src_vec;
	logic [SRC_N-1:0] src_prev_reg;
	logic tb_tick;
	logic ext_strobe;
	logic dig_trig;
	logic ana_rise;
	logic ana_prev_reg;
	logic paused;

	// Root timebase: sync line 7 when root_ext is set, else the fast internal timebase
	assign board_root_timebase_o = ctrl_reg.root_ext ?
		sync_line_i[SYNC_ROOT_LINE] : fast_internal_timebase_i;
	assign src_vec = {board_root_timebase_o, slow_internal_timebase_i,
		fast_internal_timebase_i, sync_line_i, pfi_i};

	always_ff @(posedge clk_sys_i or negedge rst_n) begin
		if (!rst_n) begin
			src_prev_reg <= '0;
			ana_prev_reg <= 1'b0;
		end else begin
			src_prev_reg <= src_vec;
			ana_prev_reg <= analog_threshold_event_i;
		end
	end

	assign tb_tick = edge_of(pick(src_vec, route_reg.tb_src),
		pick(src_prev_reg, route_reg.tb_src), ctrl_reg.tb_fall);
	assign ext_strobe = edge_of(pick(src_vec, route_reg.strobe_src),
		pick(src_prev_reg, route_reg.strobe_src), 1'b0);
	assign dig_trig = edge_of(pick(src_vec, route_reg.trig_src),
		pick(src_prev_reg, route_reg.trig_src), ctrl_reg.trig_fall);
	assign ana_rise = analog_threshold_event_i & ~ana_prev_reg;

	// Hold gate reaches a pin output only by masking the update strobe
	always_comb begin
		case (ctrl_reg.hold_mode)
			HOLD_DIG: paused = pick(src_vec, route_reg.hold_src) ^
				ctrl_reg.hold_low;
			HOLD_ANA: paused = analog_threshold_event_i;
			default: paused = 1'b0;
		endcase
	end

	// ----------------------------------------
	// Run control and divider
	// ----------------------------------------
	logic trig_hit;
	logic fire;
	logic tick_due;
	logic finished;
	logic [CNT_W-1:0] div_cnt_reg;
	logic trig_pulse_reg;

	always_comb begin
		case (ctrl_reg.trig_mode)
			TRIG_DIG: trig_hit = dig_trig;
			TRIG_ANA: trig_hit = ana_rise;
			default: trig_hit = 1'b1;
		endcase
	end

	assign tick_due = tb_tick && (div_cnt_reg <= CNT_W'(1));
	always_comb begin
		case (state_reg)
			AOWTE_DELAY: fire = tick_due;
			AOWTE_RUN: fire = ctrl_reg.strobe_ext ? ext_strobe : tick_due;
			default: fire = 1'b0;
		endcase
	end
	// Paused pulses are not counted toward a finite run
	assign finished = ctrl_reg.finite && fire && !paused &&
		(produced_reg + CNT_W'(1) >= count_reg);

	always_ff @(posedge clk_sys_i or negedge rst_n) begin
		if (!rst_n) begin
			state_reg <= AOWTE_IDLE;
		end else if (stop_cmd) begin
			state_reg <= AOWTE_IDLE;
		end else begin
			case (state_reg)
				AOWTE_IDLE: begin
					if (start_cmd) begin
						state_reg <= AOWTE_ARMED;
					end
				end
				AOWTE_ARMED: begin
					if (trig_hit) begin
						state_reg <= ctrl_reg.strobe_ext ?
							AOWTE_RUN : AOWTE_DELAY;
					end
				end
				AOWTE_DELAY: begin
					if (finished) begin
						state_reg <= AOWTE_IDLE;
					end else if (fire) begin
						state_reg <= AOWTE_RUN;
					end
				end
				AOWTE_RUN: begin
					if (finished) begin
						state_reg <= AOWTE_IDLE;
					end
				end
				default: state_reg <= AOWTE_IDLE;
			endcase
		end
	end

	always_ff @(posedge clk_sys_i or negedge rst_n) begin
		if (!rst_n) begin
			div_cnt_reg <= '0;
		end else if (state_reg == AOWTE_ARMED) begin
			div_cnt_reg <= delay_reg;
		end else if (fire) begin
			div_cnt_reg <= divisor_reg;
		end else if (tb_tick && div_cnt_reg != '0) begin
			div_cnt_reg <= div_cnt_reg - CNT_W'(1);
		end
	end

	always_ff @(posedge clk_sys_i or negedge rst_n) begin
		if (!rst_n) begin
			trig_pulse_reg <= 1'b0;
		end else begin
			trig_pulse_reg <= (state_reg == AOWTE_ARMED) && trig_hit
				&& !stop_cmd;
		end
	end
	assign run_trigger_pin_o = trig_pulse_reg;
	assign run_trigger_pin_oe_o = ctrl_reg.trig_oe;

	// ----------------------------------------
	// Strobe, hold gate and converter update
	// ----------------------------------------
	// The gate is looked at only when a new sample starts, so a
	// falling-edge update already launched still completes.
	logic strobe_reg;
	logic strobe_prev_reg;
	logic upd_evt;
	logic dac_update_reg;
	logic [DATA_W-1:0] dac_data_reg;

	always_ff @(posedge clk_sys_i or negedge rst_n) begin
		if (!rst_n) begin
			strobe_reg <= 1'b0;
			strobe_prev_reg <= 1'b0;
		end else begin
			strobe_reg <= fire && !paused && !stop_cmd;
			strobe_prev_reg <= strobe_reg;
		end
	end
	assign update_strobe_pin_o = strobe_reg;
	assign update_strobe_pin_oe_o = ctrl_reg.strobe_oe;

	assign upd_evt = edge_of(strobe_reg, strobe_prev_reg,
		ctrl_reg.upd_fall);
	assign fifo_pop_o = upd_evt && fifo_valid_i;

	always_ff @(posedge clk_sys_i or negedge rst_n) begin
		if (!rst_n) begin
			dac_update_reg <= 1'b0;
			dac_data_reg <= '0;
		end else begin
			dac_update_reg <= fifo_pop_o;
			if (fifo_pop_o) begin
				dac_data_reg <= fifo_data_i;
			end
		end
	end
	assign dac_update_o = dac_update_reg;
	assign dac_data_o = dac_data_reg;

	always_ff @(posedge clk_sys_i or negedge rst_n) begin
		if (!rst_n) begin
			produced_reg <= '0;
		end else if (start_cmd && state_reg == AOWTE_IDLE) begin
			produced_reg <= '0;
		end else if (fire && !paused) begin
			produced_reg <= produced_reg + CNT_W'(1);
		end
	end

	// Set wins over a same-cycle clear
	always_ff @(posedge clk_sys_i or negedge rst_n) begin
		if (!rst_n) begin
			underflow_reg <= 1'b0;
		end else if (upd_evt && !fifo_valid_i && ctrl_reg.noregen &&
			!ctrl_reg.finite) begin
			underflow_reg <= 1'b1;
		end else if (uf_clear) begin
			underflow_reg <= 1'b0;
		end
	end
	assign underflow_o = underflow_reg;

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	sequence seq_trigger;
		(state_reg == AOWTE_ARMED) && trig_hit && !stop_cmd;
	endsequence
	sequence seq_new_sample;
		fire && !paused && !stop_cmd;
	endsequence

	chk_trig_pulse: assert property (@(posedge clk_sys_i) disable iff (!rst_n)
		seq_trigger |=> run_trigger_pin_o ##1 !run_trigger_pin_o)
		else $error("run trigger pulse wrong");
	chk_trig_oe_sw: assert property (@(posedge clk_sys_i)
		disable iff (!rst_n) $rose(run_trigger_pin_oe_o) |->
		$past(wr_ctrl))
		else $error("run trigger pin left input mode unasked");
	chk_strobe_oe_sw: assert property (@(posedge clk_sys_i)
		disable iff (!rst_n) $rose(update_strobe_pin_oe_o) |->
		$past(wr_ctrl))
		else $error("strobe pin left input mode unasked");
	chk_hold_masks: assert property (@(posedge clk_sys_i)
		disable iff (!rst_n) fire && paused |=> !strobe_reg)
		else $error("strobe not masked by hold gate");
	chk_sample_pop: assert property (@(posedge clk_sys_i)
		disable iff (!rst_n) seq_new_sample ##1 (!ctrl_reg.upd_fall &&
		fifo_valid_i) |=> dac_update_o)
		else $error("strobe did not update converters");
	chk_fall_update: assert property (@(posedge clk_sys_i)
		disable iff (!rst_n) strobe_reg && ctrl_reg.upd_fall |=>
		upd_evt)
		else $error("falling edge update missed");
	chk_divisor_reload: assert property (@(posedge clk_sys_i)
		disable iff (!rst_n) fire && !stop_cmd && !finished &&
		$stable(divisor_reg) |=> div_cnt_reg == $past(divisor_reg))
		else $error("divider not reloaded");
	chk_stop_cmd: assert property (@(posedge clk_sys_i)
		disable iff (!rst_n) stop_cmd |=> state_reg == AOWTE_IDLE
		&& !strobe_reg)
		else $error("stop command ignored");
	chk_underflow_set: assert property (@(posedge clk_sys_i)
		disable iff (!rst_n) upd_evt && !fifo_valid_i && ctrl_reg.noregen
		&& !ctrl_reg.finite |=> underflow_o)
		else $error("underflow not flagged");
	chk_trig_to_delay: assert property (@(posedge clk_sys_i)
		disable iff (!rst_n) seq_trigger and (!ctrl_reg.strobe_ext) |=>
		state_reg == AOWTE_DELAY && div_cnt_reg == delay_reg)
		else $error("start delay not loaded");
endmodule : aowte_engine

// ==== core/aowte_pkg.sv ====
// Package: constants, register map and carrier types of the output timing engine
package aowte_pkg;
	// ----------------------------------------
	// Register map (byte addresses)
	// ----------------------------------------
	localparam logic [7:0] ADDR_CTRL = 8'h00;
	localparam logic [7:0] ADDR_ROUTE = 8'h04;
	localparam logic [7:0] ADDR_DIVISOR = 8'h08;
	localparam logic [7:0] ADDR_DELAY = 8'h0c;
	localparam logic [7:0] ADDR_COUNT = 8'h10;
	localparam logic [7:0] ADDR_STATUS = 8'h14;
	localparam logic [7:0] ADDR_PRODUCED = 8'h18;
	localparam int CTRL_START_BIT = 0;
	localparam int CTRL_STOP_BIT = 1;
	localparam int STAT_UNDERFLOW_BIT = 4;
	localparam int CNT_W = 24;
	localparam logic [CNT_W-1:0] DELAY_RESET = 24'h000002;
	localparam logic [CNT_W-1:0] DIVISOR_RESET = 24'h000002;
	localparam logic [CNT_W-1:0] COUNT_RESET = 24'h000000;
	localparam int SEL_W = 5;
	localparam int SYNC_N = 8;
	localparam int SYNC_ROOT_LINE = 7;
	// ----------------------------------------
	// Source limits, checked by the external party
	// ----------------------------------------
	localparam int TB_EXT_MAX_HZ = 20000000;
	localparam int TB_EXT_MIN_PHASE_NS = 10;
	localparam int ROOT_EXT_MAX_HZ = 20000000;
	localparam int ROOT_EXT_MIN_PHASE_NS = 23;
	// ----------------------------------------
	// Modes and states
	// ----------------------------------------
	localparam logic [1:0] TRIG_SW = 2'h0;
	localparam logic [1:0] TRIG_DIG = 2'h1;
	localparam logic [1:0] TRIG_ANA = 2'h2;
	localparam logic [1:0] HOLD_OFF = 2'h0;
	localparam logic [1:0] HOLD_DIG = 2'h1;
	localparam logic [1:0] HOLD_ANA = 2'h2;
	typedef enum logic [3:0] {
		AOWTE_IDLE = 4'h1,
		AOWTE_ARMED = 4'h2,
		AOWTE_DELAY = 4'h4,
		AOWTE_RUN = 4'h8
	} aowte_state_t;
	typedef struct packed {
		logic strobe_ext;
		logic [1:0] hold_mode;
		logic [1:0] trig_mode;
		logic hold_low;
		logic trig_fall;
		logic tb_fall;
		logic root_ext;
		logic noregen;
		logic finite;
		logic upd_fall;
		logic strobe_oe;
		logic trig_oe;
		logic stop;
		logic start;
	} aowte_ctrl_t;
	localparam aowte_ctrl_t CTRL_RESET = 16'h0000;
	typedef struct packed {
		logic [SEL_W-1:0] hold_src;
		logic [SEL_W-1:0] trig_src;
		logic [SEL_W-1:0] strobe_src;
		logic [SEL_W-1:0] tb_src;
	} aowte_route_t;
	localparam aowte_route_t ROUTE_RESET = 20'h00000;
endpackage : aowte_pkg

// ==== bench/aowte_src_model.sv ====
// External timebase and sync line sources facing the timing engine
`timescale 1ns/1ps
module aowte_src_model (
	input wire logic clk_i,
	input wire logic tb_en_i,
	input wire logic [7:0] half_i,
	input wire logic root_en_i,
	input wire logic [7:0] pulse_i,
	output logic tb_o,
	output logic [7:0] sync_o
);
	logic [7:0] cnt_reg = 8'h00;
	logic [7:0] hold_reg = 8'h00;
	logic wrap;
	initial begin
		tb_o = 1'b0;
		sync_o = 8'h00;
	end
	assign wrap = (cnt_reg + 8'h01) >= half_i;
	// Phases of half_i clocks of 40 ns; stands low when disabled
	always @(posedge clk_i) begin
		cnt_reg <= wrap ? 8'h00 : cnt_reg + 8'h01;
		if (!tb_en_i) tb_o <= 1'b0;
		else if (wrap) tb_o <= !tb_o;
	end
	// Pulses held two clocks so a synchroniser cannot miss them
	always @(posedge clk_i) begin
		hold_reg <= pulse_i;
		sync_o[6:0] <= pulse_i[6:0] | hold_reg[6:0];
		// 40 ns phases, 12.5 MHz: inside the root source limits
		sync_o[7] <= root_en_i & !sync_o[7];
	end
endmodule : aowte_src_model

// ==== bench/testbench.sv ====
// Self-checking bench of the output waveform timing engine
`timescale 1ns/1ps
module testbench
	import aowte_pkg::*;
;
	localparam int LIMIT = 20000;
	logic clk_sys_i = 1'b0;
	logic resetn_i = 1'b0;
	logic [7:0] reg_addr_i = 8'h00;
	logic [31:0] reg_wdata_i = 32'h0;
	logic reg_wr_i = 1'b0;
	logic reg_rd_i = 1'b0;
	logic [31:0] reg_rdata_o;
	logic hold_pin = 1'b0;
	logic ext_tb;
	logic [7:0] sync_line_i;
	logic [7:0] pulse_q = 8'h00;
	logic root_en = 1'b0;
	logic fast_tb = 1'b0;
	logic slow_tb = 1'b0;
	logic [2:0] slow_cnt = 3'h0;
	logic thr = 1'b0;
	logic trig_o, trig_oe, strobe_o, strobe_oe, root_o;
	logic fifo_valid_i = 1'b1;
	logic [31:0] fifo_data_i = 32'h100;
	logic fifo_pop_o, dac_update_o, underflow_o;
	logic [31:0] dac_data_o, popped, v;
	int errors = 0, total_checks = 0, cyc = 0, per;
	int n_str, n_pop, n_upd, n_trig, t_str, t_trig, gap, dly, lag;
	logic [7:0] ra [8] = '{ADDR_CTRL, ADDR_ROUTE, ADDR_DIVISOR, ADDR_DELAY,
		ADDR_COUNT, ADDR_STATUS, ADDR_PRODUCED, 8'h1c};
	logic [31:0] rv [8] = '{0, 0, 2, 2, 0, 1, 0, 0};
	always #20 clk_sys_i = ~clk_sys_i;
	aowte_engine dut_u (.clk_sys_i(clk_sys_i), .resetn_i(resetn_i),
		.reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
		.reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
		.pfi_i({8'h00, hold_pin, ext_tb}), .sync_line_i(sync_line_i),
		.fast_internal_timebase_i(fast_tb), .slow_internal_timebase_i(slow_tb),
		.analog_threshold_event_i(thr), .run_trigger_pin_i(1'b0),
		.run_trigger_pin_o(trig_o), .run_trigger_pin_oe_o(trig_oe),
		.update_strobe_pin_i(1'b0), .update_strobe_pin_o(strobe_o),
		.update_strobe_pin_oe_o(strobe_oe), .board_root_timebase_o(root_o),
		.fifo_valid_i(fifo_valid_i), .fifo_data_i(fifo_data_i),
		.fifo_pop_o(fifo_pop_o), .dac_data_o(dac_data_o),
		.dac_update_o(dac_update_o), .underflow_o(underflow_o));
	aowte_src_model src_u (.clk_i(clk_sys_i), .tb_en_i(1'b1),
		.half_i(8'h03), .root_en_i(root_en), .pulse_i(pulse_q),
		.tb_o(ext_tb), .sync_o(sync_line_i));
	// ----------------------------------------
	// Tasks
	// ----------------------------------------
	task automatic chk(input string nm, input logic [31:0] e,
		input logic [31:0] g);
		total_checks++;
		if (g !== e) begin
			errors++;
			$display("[ERR] %s expected %h seen %h", nm, e, g);
		end
	endtask : chk
	task automatic results();
		$display("checks %0d errors %0d", total_checks, errors);
		if (errors == 0 && total_checks > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask : results
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_sys_i);
		reg_wr_i <= 1'b1;
		reg_addr_i <= a;
		reg_wdata_i <= d;
		@(posedge clk_sys_i);
		reg_wr_i <= 1'b0;
	endtask : wr
	task automatic rd(input logic [7:0] a, output logic [31:0] d);
		@(posedge clk_sys_i);
		reg_rd_i <= 1'b1;
		reg_addr_i <= a;
		@(posedge clk_sys_i);
		reg_rd_i <= 1'b0;
		#1 d = reg_rdata_o;
	endtask : rd
	task automatic wait_state(input logic [3:0] st);
		logic [31:0] s;
		for (int i = 0; i < 300; i++) begin
			rd(ADDR_STATUS, s);
			if (s[3:0] === st) break;
		end
		chk("state", {28'h0, st}, {28'h0, s[3:0]});
		repeat (4) @(posedge clk_sys_i);
	endtask : wait_state
	// Counters are cleared off the edge so the monitor never races it
	task automatic clr();
		repeat (4) @(negedge clk_sys_i);
		n_str = 0;
		n_pop = 0;
		n_upd = 0;
		n_trig = 0;
	endtask : clr
	task automatic pulse(input int n);
		@(posedge clk_sys_i);
		pulse_q <= 8'h01 << n;
		@(posedge clk_sys_i);
		pulse_q <= 8'h00;
		repeat (8) @(posedge clk_sys_i);
	endtask : pulse
	task automatic pause(input int n);
		repeat (n) @(negedge clk_sys_i);
	endtask : pause
	// ----------------------------------------
	// Monitor and stimulus
	// ----------------------------------------
	always @(posedge clk_sys_i) begin
		fast_tb <= !fast_tb;
		slow_cnt <= slow_cnt + 3'h1;
		if (slow_cnt == 3'h7) slow_tb <= !slow_tb;
	end
	always @(posedge clk_sys_i) begin
		cyc++;
		if (fifo_pop_o) begin
			fifo_data_i <= fifo_data_i + 32'h1;
			popped <= fifo_data_i;
			n_pop++;
		end
		if (trig_o) begin
			n_trig++;
			t_trig = cyc;
		end
		if (strobe_o) begin
			gap = cyc - t_str;
			t_str = cyc;
			if (n_str == 0) dly = cyc - t_trig;
			n_str++;
		end
		if (dac_update_o) begin
			lag = cyc - t_str;
			n_upd++;
			chk("dac_data", popped, dac_data_o);
		end
		if (cyc == LIMIT) begin
			errors++;
			results();
		end
	end
	initial begin
		repeat (10) @(posedge clk_sys_i);
		resetn_i <= 1'b1;
		pause(3);
		chk("trig_oe", 0, trig_oe);
		chk("strobe_oe", 0, strobe_oe);
		for (int i = 0; i < 8; i++) begin
			rd(ra[i], v);
			chk("reset_value", rv[i], v);
		end
		wr(ADDR_DELAY, 32'h5);
		rd(ADDR_DELAY, v);
		chk("delay_prog", 32'h5, v);
		wr(ADDR_DELAY, 32'h2);
		// Finite runs: external pin timebase, then slow timebase on falls
		for (int k = 0; k < 2; k++) begin
			per = k ? 16 : 6;
			wr(ADDR_ROUTE, k ? 32'h13 : 32'h0);
			wr(ADDR_COUNT, 32'h3);
			clr();
			wr(ADDR_CTRL, k ? 32'h13d : 32'h2d);
			wait_state(AOWTE_IDLE);
			chk("trig_pulses", 1, n_trig);
			chk("strobes", 3, n_str);
			chk("updates", 3, n_upd);
			chk("pops", 3, n_pop);
			chk("strobe_gap", 2 * per, gap);
			chk("first_delay", 1, dly >= per && dly <= 2 * per + 4);
			chk("update_lag", k ? 2 : 1, lag);
			rd(ADDR_PRODUCED, v);
			chk("produced", 32'h3, v);
		end
		chk("trig_oe_on", 1, trig_oe);
		chk("strobe_oe_on", 1, strobe_oe);
		// Hold gate from a function pin, both pausing levels
		hold_pin <= 1'b1;
		wr(ADDR_ROUTE, 32'h8000);
		wr(ADDR_CTRL, 32'h2009);
		clr();
		pause(100);
		chk("held", 0, n_str);
		wr(ADDR_CTRL, 32'h2408);
		for (int i = 0; i < 200 && !strobe_o; i++) pause(1);
		hold_pin <= 1'b0;
		pause(3);
		chk("update_kept", n_str, n_upd);
		clr();
		pause(60);
		chk("held_low", 0, n_str);
		thr <= 1'b1;
		wr(ADDR_CTRL, 32'h4008);
		clr();
		pause(60);
		chk("analog_held", 0, n_str);
		thr <= 1'b0;
		pause(60);
		chk("analog_free", 1, n_str > 0);
		wr(ADDR_CTRL, 32'h2);
		clr();
		pause(60);
		chk("stopped", 0, n_str);
		// Underflow with an empty FIFO in continuous mode
		fifo_valid_i <= 1'b0;
		clr();
		wr(ADDR_CTRL, 32'h41);
		pause(60);
		chk("underflow", 1, underflow_o);
		chk("empty_moves", 0, n_pop + n_upd);
		wr(ADDR_CTRL, 32'h2);
		rd(ADDR_STATUS, v);
		chk("status_uf", 32'h11, v);
		wr(ADDR_STATUS, 32'h10);
		rd(ADDR_STATUS, v);
		chk("uf_clear", 32'h1, v);
		fifo_valid_i <= 1'b1;
		// Digital trigger on sync line 2, strobes from sync line 3
		wr(ADDR_ROUTE, 32'h31a0);
		wr(ADDR_COUNT, 32'h4);
		clr();
		wr(ADDR_CTRL, 32'h882d);
		pause(20);
		rd(ADDR_STATUS, v);
		chk("armed", 32'h2, v);
		pulse(2);
		for (int i = 0; i < 4; i++) pulse(3);
		wait_state(AOWTE_IDLE);
		chk("dig_trig", 1, n_trig);
		chk("ext_strobes", 4, n_str);
		// Analog trigger needs a rising edge, not a high level
		thr <= 1'b1;
		wr(ADDR_ROUTE, 32'h0);
		wr(ADDR_COUNT, 32'h1);
		clr();
		wr(ADDR_CTRL, 32'h1021);
		pause(20);
		rd(ADDR_STATUS, v);
		chk("ana_armed", 32'h2, v);
		thr <= 1'b0;
		pause(4);
		thr <= 1'b1;
		wait_state(AOWTE_IDLE);
		chk("ana_strobes", 1, n_str);
		// Root timebase source selection
		root_en <= 1'b1;
		wr(ADDR_CTRL, 32'h0);
		for (int i = 0; i < 4; i++) begin
			pause(1);
			chk("root_fast", fast_tb, root_o);
		end
		wr(ADDR_CTRL, 32'h80);
		for (int i = 0; i < 4; i++) begin
			pause(1);
			chk("root_sync7", sync_line_i[7], root_o);
		end
		results();
	end
endmodule : testbench
